// ### digrr_regs.svh
//------------------------------------------------------------------------------
// Register map and timing constants of the digital channel record and replay block.
//------------------------------------------------------------------------------
// Purpose: offsets, field positions, reset values and timing counts.
// Assumes: 4-bit byte address, 8-bit register data.
// Notes: definitions only.
//
// Behaviour
// - One or two capture channels by variant.
// - Channel bits captured with each RF sample.
// - Channel two needs two RF channels or 2-bit.
// - Pulse-per-second passes only with position fix.
// - Battery save stops receiver 30 s into recording.
// - Replayed pulse-per-second drives event output.
// - CAN lines one and two map to channels.
// - Serial source captured as raw waveform.
// - Replayed serial waveform drives serial output.
// - Serial needs no baud rate setting.
// - Event source samples event input level.
// - Replayed event channel drives event output.
// - External reference select follows its option.
// - Indicator shown while external reference enabled.
// - Battery save dims, stops receiver after 30 s idle.
`ifndef DIGRR_REGS_SVH
`define DIGRR_REGS_SVH

// Register offsets.
`define DIGRR_OFF_CTRL 4'h0
`define DIGRR_OFF_SRC 4'h1
`define DIGRR_OFF_RFCFG 4'h2
`define DIGRR_OFF_STATUS 4'h3

// Control register fields.
`define DIGRR_CTRL_REC 0
`define DIGRR_CTRL_PLAY 1
`define DIGRR_CTRL_EXTREF 2
`define DIGRR_CTRL_PSAVE 3

// Source register fields.
`define DIGRR_SRC_CH1_LO 0
`define DIGRR_SRC_CH2_LO 2
`define DIGRR_SRC_CH2_EN 4

// RF configuration fields.
`define DIGRR_RF_CNT_LO 0
`define DIGRR_RF_TWOBIT 2

// Status register fields.
`define DIGRR_ST_CH2 0
`define DIGRR_ST_GNSS 1
`define DIGRR_ST_FIX 2
`define DIGRR_ST_DIM 3
`define DIGRR_ST_EVT 4
`define DIGRR_ST_PLAY 5
`define DIGRR_ST_REC 6

// Reset values: power save on, one RF channel, channel one on event input.
`define DIGRR_RST_CTRL 8'h08
`define DIGRR_RST_SRC 8'h03
`define DIGRR_RST_RFCFG 8'h01

// Timing: clock rate and battery save delay.
`define DIGRR_CLK_HZ 40000000
`define DIGRR_SEC_S 1
`define DIGRR_SEC_CYCLES (`DIGRR_CLK_HZ * `DIGRR_SEC_S)
`define DIGRR_PS_DELAY_S 30

`endif

// ### digrr_pkg.sv
//------------------------------------------------------------------------------
// Types of the digital channel record and replay block.
//------------------------------------------------------------------------------
// Purpose: shared enumerations, structs and source decoding.
// Assumes: two channels at most.
// Notes: source codes follow enum order.
package digrr_pkg;

   // Source selected for one capture channel.
   typedef enum logic [1:0] {
      DIGRR_SRC_PPS,
      DIGRR_SRC_CAN,
      DIGRR_SRC_SERIAL,
      DIGRR_SRC_EVENT
   } digrr_src_t;

   // Operating mode of the block.
   typedef enum logic [1:0] {
      DIGRR_IDLE,
      DIGRR_RECORD,
      DIGRR_REPLAY
   } digrr_mode_t;

   // External digital inputs.
   typedef struct packed {
      logic pps;
      logic can1;
      logic can2;
      logic serial;
      logic event_in;
   } digrr_pins_t;

   // One RF sample's worth of digital channel bits.
   typedef struct packed {
      logic valid;
      logic [1:0] bits;
   } digrr_sample_t;

   // Sources that replay onto the event output.
   function automatic logic digrr_to_event(input digrr_src_t s);
      digrr_to_event = (s == DIGRR_SRC_PPS) || (s == DIGRR_SRC_EVENT);
   endfunction

endpackage

// ### digrr_chan.sv
//------------------------------------------------------------------------------
// One capture channel source selector.
//------------------------------------------------------------------------------
// Purpose: pick the level one channel samples from its selected source.
// Assumes: inputs synchronous to mclk.
// Notes: combinational; the caller registers the result.
`timescale 1ns/1ps
module digrr_chan #(
   parameter int CHAN_IDX = 0
) (
   // Source selection.
   input wire digrr_pkg::digrr_src_t src,
   // Pin levels, pulse-per-second already gated.
   input wire digrr_pkg::digrr_pins_t pins,
   // Selected level.
   output logic level
);

   // CAN line of this channel: first line on channel one, second on two.
   wire can_line = (CHAN_IDX == 0) ? pins.can1 : pins.can2;

   // Raw level per source; serial is sampled, never decoded.
   always_comb begin
      case (src)
         digrr_pkg::DIGRR_SRC_PPS: level = pins.pps;
         digrr_pkg::DIGRR_SRC_CAN: level = can_line;
         digrr_pkg::DIGRR_SRC_SERIAL: level = pins.serial;
         digrr_pkg::DIGRR_SRC_EVENT: level = pins.event_in;
         default: level = 1'b0;
      endcase
   end

endmodule

// ### digrr_top.sv
//------------------------------------------------------------------------------
// Digital channel record and replay.
//------------------------------------------------------------------------------
// Purpose: capture side channels with each RF sample and replay them.
// Assumes: all inputs synchronous to mclk; one sample strobe per RF sample.
// Notes: capture bits appear one cycle after the sample strobe.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "digrr_regs.svh"
module digrr_top #(
   parameter int NUM_CH = 2,
   parameter int TICK_CYCLES = `DIGRR_SEC_CYCLES,
   parameter int PS_DELAY_S = `DIGRR_PS_DELAY_S
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Register port.
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // External digital inputs and receiver state.
   input wire digrr_pkg::digrr_pins_t pins,
   input wire logic gnss_fix,
   input wire logic on_battery,
   input wire logic user_activity,
   // RF sample stream.
   input wire logic rec_sample,
   output digrr_pkg::digrr_sample_t cap_out,
   input wire digrr_pkg::digrr_sample_t play_in,
   // Digital outputs.
   output logic event_output,
   output logic serial_tx,
   output logic can1_tx,
   output logic can2_tx,
   // Platform controls.
   output logic gnss_power_en,
   output logic backlight_dim,
   output logic ref_ext_sel,
   output logic ref_icon
);

   //---------------------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------------------
   logic [7:0] ctrl_reg;
   logic [7:0] src_reg;
   logic [7:0] rfcfg_reg;
   logic [7:0] rdata_reg;
   digrr_pkg::digrr_mode_t mode_reg;
   digrr_pkg::digrr_mode_t mode_next;
   digrr_pkg::digrr_sample_t cap_reg;
   logic evt_reg;
   logic ser_reg;
   logic can1_reg;
   logic can2_reg;
   logic [$clog2(TICK_CYCLES)-1:0] div_reg;
   logic [5:0] rec_sec_reg;
   logic [5:0] idle_sec_reg;

   // Write decode.
   wire wr_ctrl = wr && (addr == `DIGRR_OFF_CTRL);
   wire wr_src = wr && (addr == `DIGRR_OFF_SRC);
   wire wr_rfcfg = wr && (addr == `DIGRR_OFF_RFCFG);

   // Control fields.
   wire rec_en = ctrl_reg[`DIGRR_CTRL_REC];
   wire play_en = ctrl_reg[`DIGRR_CTRL_PLAY];
   wire ext_ref = ctrl_reg[`DIGRR_CTRL_EXTREF];
   wire psave = ctrl_reg[`DIGRR_CTRL_PSAVE];
   wire [1:0] rf_cnt = rfcfg_reg[`DIGRR_RF_CNT_LO +: 2];
   wire two_bit = rfcfg_reg[`DIGRR_RF_TWOBIT];

   // Channel sources.
   wire digrr_pkg::digrr_src_t src1 =
      digrr_pkg::digrr_src_t'(src_reg[`DIGRR_SRC_CH1_LO +: 2]);
   wire digrr_pkg::digrr_src_t src2 =
      digrr_pkg::digrr_src_t'(src_reg[`DIGRR_SRC_CH2_LO +: 2]);

   // Second channel exists only on two-channel builds and with enough RF width.
   wire ch2_rf_ok = (rf_cnt >= 2'h2) || ((rf_cnt == 2'h1) && two_bit);
   wire ch2_on = (NUM_CH > 1) && src_reg[`DIGRR_SRC_CH2_EN] && ch2_rf_ok;

   // Register writes; reserved bits are kept at zero.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `DIGRR_RST_CTRL;
         src_reg <= `DIGRR_RST_SRC;
         rfcfg_reg <= `DIGRR_RST_RFCFG;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= {4'h0, wdata[3:0]};
         end
         if (wr_src) begin
            src_reg <= {3'h0, wdata[4:0]};
         end
         if (wr_rfcfg) begin
            rfcfg_reg <= {5'h00, wdata[2:0]};
         end
      end
   end

   //---------------------------------------------------------------------------
   // Mode control
   //---------------------------------------------------------------------------
   // Record has priority over replay when both are requested.
   always_comb begin
      case (mode_reg)
         digrr_pkg::DIGRR_IDLE: begin
            if (rec_en) begin
               mode_next = digrr_pkg::DIGRR_RECORD;
            end else if (play_en) begin
               mode_next = digrr_pkg::DIGRR_REPLAY;
            end else begin
               mode_next = digrr_pkg::DIGRR_IDLE;
            end
         end
         digrr_pkg::DIGRR_RECORD: begin
            mode_next = rec_en ? digrr_pkg::DIGRR_RECORD : digrr_pkg::DIGRR_IDLE;
         end
         digrr_pkg::DIGRR_REPLAY: begin
            mode_next = (play_en && !rec_en) ? digrr_pkg::DIGRR_REPLAY
                                             : digrr_pkg::DIGRR_IDLE;
         end
         default: mode_next = digrr_pkg::DIGRR_IDLE;
      endcase
   end

   // Mode state register.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg <= digrr_pkg::DIGRR_IDLE;
      end else begin
         mode_reg <= mode_next;
      end
   end

   wire recording = (mode_reg == digrr_pkg::DIGRR_RECORD);
   wire replaying = (mode_reg == digrr_pkg::DIGRR_REPLAY);

   //---------------------------------------------------------------------------
   // Battery save timing
   //---------------------------------------------------------------------------
   // One-second enable pulse from the clock divider.
   wire sec_tick = (div_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
   wire [5:0] ps_limit = 6'(PS_DELAY_S);
   wire rec_done = (rec_sec_reg >= ps_limit);
   wire idle_done = (idle_sec_reg >= ps_limit);
   wire save_act = psave && on_battery;

   // Divider for the one-second enable.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg <= '0;
      end else begin
         div_reg <= sec_tick ? '0 : div_reg + 1'b1;
      end
   end

   // Seconds since recording began, saturating at the save delay.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rec_sec_reg <= 6'h00;
      end else if (!recording) begin
         rec_sec_reg <= 6'h00;
      end else if (sec_tick && !rec_done) begin
         rec_sec_reg <= rec_sec_reg + 6'h01;
      end
   end

   // Seconds since the last user activity, saturating at the save delay.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idle_sec_reg <= 6'h00;
      end else if (user_activity) begin
         idle_sec_reg <= 6'h00;
      end else if (sec_tick && !idle_done) begin
         idle_sec_reg <= idle_sec_reg + 6'h01;
      end
   end

   // Receiver power and backlight under battery save.
   wire rx_off = save_act && ((recording && rec_done) || idle_done);
   assign gnss_power_en = !rx_off;
   assign backlight_dim = save_act && idle_done;

   //---------------------------------------------------------------------------
   // Reference clock selection
   //---------------------------------------------------------------------------
   // The clock mux and display indicator follow the option bit.
   assign ref_ext_sel = ext_ref;
   assign ref_icon = ext_ref;

   //---------------------------------------------------------------------------
   // Capture
   //---------------------------------------------------------------------------
   // Pulse-per-second only passes with a fix and a powered receiver.
   wire pps_ok = pins.pps && gnss_fix && gnss_power_en;
   wire digrr_pkg::digrr_pins_t pins_g = '{
      pps: pps_ok,
      can1: pins.can1,
      can2: pins.can2,
      serial: pins.serial,
      event_in: pins.event_in
   };
   wire digrr_pkg::digrr_src_t srcs [2] = '{src1, src2};
   logic [1:0] cap_lvl;

   // One source selector per channel.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
         digrr_chan #(
            .CHAN_IDX(gi)
         ) u_chan (
            .src(srcs[gi]),
            .pins(pins_g),
            .level(cap_lvl[gi])
         );
      end
   endgenerate

   // Channel bits latched with each RF sample while recording.
   wire cap_take = recording && rec_sample;
   wire [1:0] cap_bits = {cap_lvl[1] && ch2_on, cap_lvl[0]};

   // Capture register: one valid cycle per RF sample.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cap_reg <= '0;
      end else begin
         cap_reg.valid <= cap_take;
         if (cap_take) begin
            cap_reg.bits <= cap_bits;
         end
      end
   end
   assign cap_out = cap_reg;

   //---------------------------------------------------------------------------
   // Replay
   //---------------------------------------------------------------------------
   // While replaying, outputs move only on a replayed sample, so edges keep their sample index.
   wire play_take = replaying && play_in.valid;
   wire b1 = play_in.bits[0];
   wire b2 = play_in.bits[1] && ch2_on;
   wire ev1 = digrr_pkg::digrr_to_event(src1);
   wire ev2 = ch2_on && digrr_pkg::digrr_to_event(src2);

   // Event output: channel one has priority when both carry event sources.
   wire evt_next = ev1 ? b1 : (ev2 ? b2 : 1'b0);
   // Serial output idles at mark when no channel carries serial.
   wire ser_next = (src1 == digrr_pkg::DIGRR_SRC_SERIAL) ? b1 :
      ((ch2_on && (src2 == digrr_pkg::DIGRR_SRC_SERIAL)) ? b2 : 1'b1);
   // CAN lines idle recessive when not carried.
   wire can1_next = (src1 == digrr_pkg::DIGRR_SRC_CAN) ? b1 : 1'b1;
   wire can2_next = (ch2_on && (src2 == digrr_pkg::DIGRR_SRC_CAN)) ? b2 : 1'b1;

   // Replay output registers; idle levels when replay stops.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         evt_reg <= 1'b0;
         ser_reg <= 1'b1;
         can1_reg <= 1'b1;
         can2_reg <= 1'b1;
      end else if (!replaying) begin
         evt_reg <= 1'b0;
         ser_reg <= 1'b1;
         can1_reg <= 1'b1;
         can2_reg <= 1'b1;
      end else if (play_take) begin
         evt_reg <= evt_next;
         ser_reg <= ser_next;
         can1_reg <= can1_next;
         can2_reg <= can2_next;
      end
   end

   assign event_output = evt_reg;
   assign serial_tx = ser_reg;
   assign can1_tx = can1_reg;
   assign can2_tx = can2_reg;

   //---------------------------------------------------------------------------
   // Register read
   //---------------------------------------------------------------------------
   // Status word built from live block state.
   wire [7:0] status_w = {
      1'b0,
      recording,
      replaying,
      evt_reg,
      backlight_dim,
      gnss_fix,
      gnss_power_en,
      ch2_on
   };

   // Read selection; unmapped offsets read zero.
   wire [7:0] rd_mux =
      (addr == `DIGRR_OFF_CTRL) ? ctrl_reg :
      (addr == `DIGRR_OFF_SRC) ? src_reg :
      (addr == `DIGRR_OFF_RFCFG) ? rfcfg_reg :
      (addr == `DIGRR_OFF_STATUS) ? status_w : 8'h00;

   // Read data stands for exactly the cycle after the strobe.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rd ? rd_mux : 8'h00;
      end
   end
   assign rdata = rdata_reg;

endmodule

// ### digrr_srcs.sv
//------------------------------------------------------------------------------
// External digital sources.
//------------------------------------------------------------------------------
// Purpose: drive the five input pins of the block.
// Assumes: requested levels come from the bench.
// Notes: a level stands at least MIN_HOLD cycles.
`timescale 1ns/1ps
module digrr_srcs #(
   parameter int MIN_HOLD = 40
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic arst_n,
   // Requested levels and driven pins.
   input wire logic [4:0] pat,
   output digrr_pkg::digrr_pins_t pins
);
   int hold_cnt;

   // A new level is taken only after the last one stood for MIN_HOLD cycles.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pins <= 5'h01; // The event input idles high through its pull-up.
         hold_cnt <= 0;
      end else if (hold_cnt != 0) begin
         hold_cnt <= hold_cnt - 1;
      end else if (pat != pins) begin
         pins <= pat;
         hold_cnt <= MIN_HOLD - 1;
      end
   end
endmodule

// ### digrr_asserts.sv
//------------------------------------------------------------------------------
// Port checker of the record and replay block.
//------------------------------------------------------------------------------
// Purpose: assertions on capture, replay, reference and power save.
// Assumes: writable registers are mirrored from the register port.
// Notes: bound into the top module.
`timescale 1ns/1ps
`include "digrr_regs.svh"
module digrr_asserts #(
   parameter int NUM_CH = 2,
   parameter int TICK_CYCLES = `DIGRR_SEC_CYCLES,
   parameter int PS_DELAY_S = `DIGRR_PS_DELAY_S
) (
   // Clock, reset and register port.
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   // Inputs and stream.
   input wire digrr_pkg::digrr_pins_t pins,
   input wire logic gnss_fix,
   input wire logic on_battery,
   input wire logic user_activity,
   input wire logic rec_sample,
   input wire digrr_pkg::digrr_sample_t cap_out,
   input wire digrr_pkg::digrr_sample_t play_in,
   // Outputs.
   input wire logic event_output,
   input wire logic serial_tx,
   input wire logic gnss_power_en,
   input wire logic backlight_dim,
   input wire logic ref_ext_sel,
   input wire logic ref_icon
);
   localparam int LIM = (PS_DELAY_S + 1) * TICK_CYCLES + 4;
   logic [7:0] ctrl_m, src_m, rf_m;
   logic rec_q, play_q, ch2_ok, pl, evt1, exp1, exp2;
   int idle_cnt, rec_cnt;

   // Mirror of the registers, mode delay and battery save counters.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_m <= `DIGRR_RST_CTRL;
         src_m <= `DIGRR_RST_SRC;
         rf_m <= `DIGRR_RST_RFCFG;
         rec_q <= 1'b0;
         play_q <= 1'b0;
         idle_cnt <= 0;
         rec_cnt <= 0;
      end else begin
         if (wr && addr == 4'h0) ctrl_m <= wdata;
         if (wr && addr == 4'h1) src_m <= wdata;
         if (wr && addr == 4'h2) rf_m <= wdata;
         // Mode mirror: record wins, and a switch between modes passes idle.
         rec_q <= ctrl_m[0] && (rec_q || !play_q);
         play_q <= ctrl_m[1] && !ctrl_m[0] && !rec_q;
         idle_cnt <= (ctrl_m[3] && on_battery && !user_activity) ? idle_cnt + 1 : 0;
         rec_cnt <= (ctrl_m[3] && on_battery && ctrl_m[0]) ? rec_cnt + 1 : 0;
      end
   end

   // Channel two permission and the expected level of each channel.
   assign ch2_ok = (NUM_CH > 1) && src_m[4] &&
      (rf_m[1:0] >= 2'h2 || (rf_m[1:0] == 2'h1 && rf_m[2]));
   assign pl = play_q && ctrl_m[1] && !ctrl_m[0];
   assign evt1 = src_m[1:0] == 2'h0 || src_m[1:0] == 2'h3;
   assign exp1 = src_m[1:0] == 2'h0 ? pins.pps && gnss_fix && gnss_power_en :
      src_m[1:0] == 2'h1 ? pins.can1 : src_m[1:0] == 2'h2 ? pins.serial : pins.event_in;
   assign exp2 = src_m[3:2] == 2'h0 ? pins.pps && gnss_fix && gnss_power_en :
      src_m[3:2] == 2'h1 ? pins.can2 : src_m[3:2] == 2'h2 ? pins.serial : pins.event_in;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   a_cap_cause: assert property (cap_out.valid |-> $past(rec_sample && rec_q))
      else $error("capture valid without a sample");
   a_cap_align: assert property (rec_sample && rec_q && ctrl_m[0] |=> cap_out.valid)
      else $error("sample not captured");
   a_ch2_gate: assert property (cap_out.valid && !$past(ch2_ok) |-> !cap_out.bits[1])
      else $error("channel two captured while not allowed");
   a_ch1_level: assert property (cap_out.valid |-> cap_out.bits[0] == $past(exp1))
      else $error("channel one level wrong");
   a_ch2_level: assert property (cap_out.valid && $past(ch2_ok) |-> cap_out.bits[1] == $past(exp2))
      else $error("channel two level wrong");
   a_replay_event: assert property (play_in.valid && pl && evt1 |=> event_output == $past(play_in.bits[0]))
      else $error("event output not replayed");
   a_replay_serial: assert property (play_in.valid && pl && src_m[1:0] == 2'h2 |=> serial_tx == $past(play_in.bits[0]))
      else $error("serial output not replayed");
   a_ref_follow: assert property (ref_ext_sel == ctrl_m[2] && ref_icon == ctrl_m[2])
      else $error("reference select or indicator wrong");
   a_idle_dim: assert property (idle_cnt >= LIM |-> backlight_dim && !gnss_power_en)
      else $error("no dim after idle time");
   a_rec_off: assert property (rec_cnt >= LIM |-> !gnss_power_en)
      else $error("receiver on late into recording");
   a_save_off: assert property (!(ctrl_m[3] && on_battery) |-> gnss_power_en && !backlight_dim)
      else $error("power save acting while not allowed");

   c_ch2: cover property (cap_out.valid && cap_out.bits[1]);
   c_dim: cover property (backlight_dim);
   c_event: cover property (pl && event_output);
endmodule

bind digrr_top digrr_asserts #(.NUM_CH(NUM_CH), .TICK_CYCLES(TICK_CYCLES),
   .PS_DELAY_S(PS_DELAY_S)) i_chk (.*);

// ### testbench.sv
//------------------------------------------------------------------------------
// Testbench of the record and replay block.
//------------------------------------------------------------------------------
// Purpose: register, capture, power save and replay tests.
// Assumes: short second tick and save delay.
// Notes: pins come from the source model.
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic gnss_fix = 1'b1;
   logic on_battery = 1'b0;
   logic user_activity = 1'b0;
   logic rec_sample = 1'b0;
   logic [4:0] pat = 5'h01;
   digrr_pkg::digrr_sample_t play_in = 3'h0;
   digrr_pkg::digrr_pins_t pins;
   digrr_pkg::digrr_sample_t cap_out;
   logic [7:0] rdata;
   logic [2:0] e;
   logic event_output, serial_tx, can1_tx, can2_tx;
   logic gnss_power_en, backlight_dim, ref_ext_sel, ref_icon;
   int n_mismatch = 0;
   int cmp_count = 0;
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin n_mismatch++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, x, g); end end

   // Clock, source model and design.
   always #12.5 mclk = ~mclk;
   digrr_srcs i_src (.*);
   digrr_top #(.TICK_CYCLES(10), .PS_DELAY_S(3)) i_dut (.*);

   // Expected level of a channel for a source code and pin pattern.
   function automatic logic xbit(input int s, input logic [4:0] p, input logic two);
      xbit = (s == 0) ? p[4] : (s == 1) ? (two ? p[2] : p[3]) : (s == 2) ? p[1] : p[0];
   endfunction

   // Register port and stream tasks.
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] x, input string n);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 `CHK(n, x, rdata)
   endtask
   task automatic take(input logic [2:0] x);
      @(posedge mclk);
      rec_sample <= 1'b1;
      @(posedge mclk);
      rec_sample <= 1'b0;
      #1 `CHK("capture", x, cap_out)
   endtask
   task automatic play(input logic [1:0] b);
      @(posedge mclk);
      play_in <= {1'b1, b};
      @(posedge mclk);
      play_in <= 3'h0;
      #1;
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog.
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      end_of_test;
   end

   // Test sequence.
   initial begin
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      rd_chk(4'h0, 8'h08, "ctrl");
      rd_chk(4'h1, 8'h03, "src");
      rd_chk(4'h2, 8'h01, "rfcfg");
      wr_reg(4'h3, 8'hFF);
      wr_reg(4'hF, 8'hFF);
      rd_chk(4'h3, 8'h06, "status");
      rd_chk(4'hF, 8'h00, "unmapped");
      take(3'h0);
      $display("test registers done");
      wr_reg(4'h0, 8'h01);
      for (int r = 0; r < 3; r++) begin
         wr_reg(4'h2, (r == 0) ? 8'h01 : (r == 1) ? 8'h05 : 8'h02);
         for (int s = 0; s < 4; s++) begin
            wr_reg(4'h1, 8'(8'h10 + 8'h05 * s));
            for (int k = 0; k < 2; k++) begin
               pat <= k ? 5'h15 : 5'h0A;
               repeat (45) @(posedge mclk);
               take({1'b1, (r != 0) && xbit(s, pat, 1'b1), xbit(s, pat, 1'b0)});
            end
         end
      end
      gnss_fix <= 1'b0;
      wr_reg(4'h1, 8'h10);
      take(3'h4);
      gnss_fix <= 1'b1;
      $display("test capture done");
      on_battery <= 1'b1;
      wr_reg(4'h0, 8'h09);
      for (int i = 0; i < 8; i++) begin
         repeat (10) @(posedge mclk);
         user_activity <= 1'b1;
         @(posedge mclk);
         user_activity <= 1'b0;
      end
      #1 `CHK("receiver power", 1'b0, gnss_power_en)
      wr_reg(4'h0, 8'h08);
      repeat (60) @(posedge mclk);
      #1 `CHK("dim", 1'b1, backlight_dim)
      user_activity <= 1'b1;
      @(posedge mclk);
      user_activity <= 1'b0;
      @(posedge mclk);
      #1 `CHK("dim", 1'b0, backlight_dim)
      on_battery <= 1'b0;
      $display("test power save done");
      wr_reg(4'h0, 8'h02);
      for (int s = 0; s < 4; s++) begin
         wr_reg(4'h1, 8'(8'h10 + 8'h05 * s));
         for (int b = 0; b < 4; b++) begin
            play(2'(b));
            `CHK("event out", (s == 0 || s == 3) ? b[0] : 1'b0, event_output)
            e = {s == 2 ? b[0] : 1'b1, s == 1 ? b[0] : 1'b1, s == 1 ? b[1] : 1'b1};
            `CHK("serial can", e, {serial_tx, can1_tx, can2_tx})
         end
      end
      wr_reg(4'h0, 8'h04);
      #1 `CHK("ref", 2'h3, {ref_ext_sel, ref_icon})
      repeat (2) @(posedge mclk);
      #1 `CHK("event idle", 1'b0, event_output)
      wr_reg(4'h0, 8'h02);
      wr_reg(4'h0, 8'h03);
      @(posedge mclk);
      rd_chk(4'h3, 8'h47, "status record");
      take(3'h7);
      $display("test replay done");
      end_of_test;
   end
endmodule
